// ===== design/asrp_device.sv
// Device end of the serial register port: slave decoder and register map.
// Assumes link pins come from another domain and are synchronised here.
// Function
// - Format bit D6 at 0x31 picks wire count
// - Clock rests high, capture on rising edge
// - Master frames each transfer with chip select low
// - Master makes the clock, idle high
// - Change data after falling, sample on rising
// - Master sets burst flag after direction bit
// - Pointer advances after every further eight pulses
// - Incrementing continues until chip select rises
// - Scattered registers need separate addressed transfers
// - Chip select high while master reconfigures clocking
// - Master link rate suits output data rate
// - Deselected line activity is not decoded here
// - Data input forced high while deselected
// - At least 150 ns deselect between transfers
// - Master ignores returned bits during writes
`timescale 1ns/10ps
module asrp_device #(
	parameter int ADDR_W = asrp_pkg::ADDR_W,
	parameter int DATA_W = asrp_pkg::DATA_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	asrp_spi_if.device spi,
	output logic reg_wr_pulse,
	output logic [ADDR_W-1:0] reg_wr_addr,
	output logic [DATA_W-1:0] reg_wr_data,
	output logic [DATA_W-1:0] format_reg,
	output logic three_wire,
	output logic selected
);
	localparam int REG_COUNT = 1 << ADDR_W;

	logic [1:0] cs_s_q;
	logic [2:0] sclk_s_q;
	logic [1:0] sdi_s_q;
	logic sel;
	logic rise;
	logic fall;
	logic byte_end;
	logic [DATA_W-1:0] byte_in;
	asrp_pkg::asrp_dev_state_type state_q;
	logic [2:0] cnt_q;
	logic [DATA_W-2:0] sh_q;
	logic burst_q;
	logic [ADDR_W-1:0] ptr_q;
	logic [ADDR_W-1:0] ptr_next;
	logic [DATA_W-1:0] regs_q [REG_COUNT];
	logic [DATA_W-1:0] tx_q;
	logic dout_q;
	logic sdo_oe_q;
	logic sdio_oe_q;
	logic wr_pulse_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic [DATA_W-1:0] wr_data_q;

	// Two flops per pin, three on sclk; sclk edges are found between its second and third
	always_ff @(posedge clk) begin
		if (rst) begin
			cs_s_q <= 2'h3;
			sclk_s_q <= 3'h7;
			sdi_s_q <= 2'h3;
		end else if (ce) begin
			cs_s_q <= {cs_s_q[0], spi.cs_n};
			sclk_s_q <= {sclk_s_q[1:0], spi.sclk};
			sdi_s_q <= {sdi_s_q[0], spi.sdi_line};
		end
	end

	// Only a low chip select opens the port; anything else on the lines is ignored
	assign sel = ~cs_s_q[1];
	assign rise = sel & sclk_s_q[1] & ~sclk_s_q[2];
	assign fall = sel & ~sclk_s_q[1] & sclk_s_q[2];
	assign byte_end = rise & (cnt_q == asrp_pkg::LAST_BIT);
	assign byte_in = {sh_q, sdi_s_q[1]};
	assign ptr_next = ptr_q + 1'b1;

	// Wire count follows the format register
	assign three_wire = regs_q[asrp_pkg::FORMAT_OFFSET][asrp_pkg::WIRE_SEL_BIT];
	assign format_reg = regs_q[asrp_pkg::FORMAT_OFFSET];

	// Bit counter cleared by every deselect; input shifter keeps its value
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= 3'h0;
			sh_q <= '0;
		end else if (ce) begin
			if (!sel) begin
				cnt_q <= 3'h0;
			end else if (rise) begin
				cnt_q <= cnt_q + 3'h1;
				sh_q <= byte_in[DATA_W-2:0];
			end
		end
	end

	// Transfer sequencer and register pointer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= asrp_pkg::DEV_IDLE;
			burst_q <= 1'b0;
			ptr_q <= '0;
		end else if (ce) begin
			if (!sel) begin
				state_q <= asrp_pkg::DEV_IDLE;
			end else begin
				unique case (state_q)
					asrp_pkg::DEV_IDLE: begin
						state_q <= asrp_pkg::DEV_CMD;
					end
					asrp_pkg::DEV_CMD: begin
						if (byte_end) begin
							// Direction first, then burst flag, then address
							burst_q <= byte_in[DATA_W-2];
							ptr_q <= byte_in[ADDR_W-1:0];
							if (byte_in[DATA_W-1]) begin
								state_q <= asrp_pkg::DEV_READ;
							end else begin
								state_q <= asrp_pkg::DEV_WRITE;
							end
						end
					end
					asrp_pkg::DEV_WRITE, asrp_pkg::DEV_READ: begin
						if (byte_end) begin
							if (burst_q) begin
								ptr_q <= ptr_next;
							end else begin
								state_q <= asrp_pkg::DEV_HALT;
							end
						end
					end
					asrp_pkg::DEV_HALT: begin
						state_q <= asrp_pkg::DEV_HALT;
					end
					default: begin
						state_q <= asrp_pkg::DEV_IDLE;
					end
				endcase
			end
		end
	end

	// Register map; a written byte lands at the current pointer
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs_q[i] <= asrp_pkg::REG_RESET;
			end
		end else if (ce) begin
			if (byte_end && state_q == asrp_pkg::DEV_WRITE) begin
				regs_q[ptr_q] <= byte_in;
			end
		end
	end

	// Write notice to the sensor side, one cycle per byte
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pulse_q <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end else if (ce) begin
			wr_pulse_q <= byte_end && state_q == asrp_pkg::DEV_WRITE;
			if (byte_end && state_q == asrp_pkg::DEV_WRITE) begin
				wr_addr_q <= ptr_q;
				wr_data_q <= byte_in;
			end
		end
	end

	// Read shifter: loads on a byte boundary, shifts out after each falling edge
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_q <= '0;
			dout_q <= 1'b1;
		end else if (ce) begin
			if (byte_end && state_q == asrp_pkg::DEV_CMD) begin
				tx_q <= regs_q[byte_in[ADDR_W-1:0]];
			end else if (byte_end && state_q == asrp_pkg::DEV_READ && burst_q) begin
				tx_q <= regs_q[ptr_next];
			end else if (fall && state_q == asrp_pkg::DEV_READ) begin
				dout_q <= tx_q[DATA_W-1];
				tx_q <= {tx_q[DATA_W-2:0], 1'b0};
			end
		end
	end

	// Output enables; the shared pin is only taken for read data
	always_ff @(posedge clk) begin
		if (rst) begin
			sdo_oe_q <= 1'b0;
			sdio_oe_q <= 1'b0;
		end else if (ce) begin
			sdo_oe_q <= sel & ~three_wire;
			if (!sel || !three_wire) begin
				sdio_oe_q <= 1'b0;
			end else if (fall && state_q == asrp_pkg::DEV_READ) begin
				sdio_oe_q <= 1'b1;
			end else if (state_q != asrp_pkg::DEV_READ) begin
				sdio_oe_q <= 1'b0;
			end
		end
	end

	assign spi.dev_o = dout_q;
	assign spi.dev_sdo_oe = sdo_oe_q;
	assign spi.dev_sdio_oe = sdio_oe_q;
	assign reg_wr_pulse = wr_pulse_q;
	assign reg_wr_addr = wr_addr_q;
	assign reg_wr_data = wr_data_q;
	assign selected = sel;
endmodule

// ===== design/asrp_pkg.sv
// Shared constants and state types for the accelerometer serial register port.
// Assumes both ends run on one 250 MHz system clock.
package asrp_pkg;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int LEN_W = 7;
	localparam logic [5:0] FORMAT_OFFSET = 6'h31;
	localparam int WIRE_SEL_BIT = 6;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam int CLK_PERIOD_NS = 4;
	// Least deselect time between transfers
	localparam int CS_IDLE_NS = 150;
	localparam int CS_IDLE_CYCLES = (CS_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Shortest serial clock period; 5 MHz top rate
	localparam int SCLK_PERIOD_NS = 200;
	localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		DEV_IDLE = 3'b000,
		DEV_CMD = 3'b001,
		DEV_WRITE = 3'b010,
		DEV_READ = 3'b011,
		DEV_HALT = 3'b100
	} asrp_dev_state_type;

	typedef enum logic [2:0] {
		HST_IDLE = 3'b000,
		HST_LEAD = 3'b001,
		HST_LOW = 3'b010,
		HST_HIGH = 3'b011,
		HST_GAP = 3'b100
	} asrp_hst_state_type;
endpackage

// ===== design/asrp_spi_if.sv
// Serial link between the register port and its bus master.
// Resolves the shared data line and the output line from the enables.
`timescale 1ns/10ps
interface asrp_spi_if;
	logic cs_n;
	logic sclk;
	logic host_o;
	logic host_oe;
	logic dev_o;
	logic dev_sdo_oe;
	logic dev_sdio_oe;
	logic sdi_line;
	logic sdo_line;

	// Host wins a clash; undriven lines rest high as if pulled up
	assign sdi_line = host_oe ? host_o : (dev_sdio_oe ? dev_o : 1'b1);
	assign sdo_line = dev_sdo_oe ? dev_o : 1'b1;

	modport device (
		input cs_n,
		input sclk,
		input sdi_line,
		output dev_o,
		output dev_sdo_oe,
		output dev_sdio_oe
	);

	modport host (
		output cs_n,
		output sclk,
		output host_o,
		output host_oe,
		input sdi_line,
		input sdo_line
	);
endinterface

// ===== design/asrp_host.sv
// Master end of the serial register port: frames, clocks and shifts transfers.
// Assumes the device answers on the line picked by the three_wire input.
`timescale 1ns/10ps
module asrp_host #(
	parameter int ADDR_W = asrp_pkg::ADDR_W,
	parameter int DATA_W = asrp_pkg::DATA_W,
	parameter int LEN_W = asrp_pkg::LEN_W,
	parameter int HALF_CYCLES = asrp_pkg::SCLK_HALF_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	asrp_spi_if.host spi,
	input wire logic three_wire,
	input wire logic req,
	input wire logic req_read,
	input wire logic req_burst,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [LEN_W-1:0] req_len,
	input wire logic [DATA_W-1:0] wr_data,
	output logic wr_take,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_valid,
	output logic busy
);
	asrp_pkg::asrp_hst_state_type state_q;
	logic [7:0] tmr_q;
	logic [2:0] bit_q;
	logic [LEN_W-1:0] left_q;
	logic data_q;
	logic read_q;
	logic last_q;
	logic [DATA_W-1:0] out_q;
	logic [DATA_W-1:0] in_q;
	logic [1:0] sdi_s_q;
	logic [1:0] sdo_s_q;
	logic cs_n_q;
	logic sclk_q;
	logic mosi_q;
	logic take_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic tmr_done;
	logic in_bit;
	logic [DATA_W-1:0] byte_in;

	// Returning data crosses in from the device through two flops
	always_ff @(posedge clk) begin
		if (rst) begin
			sdi_s_q <= 2'h3;
			sdo_s_q <= 2'h3;
		end else if (ce) begin
			sdi_s_q <= {sdi_s_q[0], spi.sdi_line};
			sdo_s_q <= {sdo_s_q[0], spi.sdo_line};
		end
	end

	assign in_bit = three_wire ? sdi_s_q[1] : sdo_s_q[1];
	assign byte_in = {in_q[DATA_W-2:0], in_bit};
	assign tmr_done = (tmr_q == 8'h00);

	// Framing, clock divider and shifters in one sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= asrp_pkg::HST_IDLE;
			tmr_q <= 8'h00;
			bit_q <= 3'h0;
			left_q <= '0;
			data_q <= 1'b0;
			read_q <= 1'b0;
			last_q <= 1'b0;
			out_q <= '0;
			in_q <= '0;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b1;
			mosi_q <= 1'b1;
			take_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
		end else if (ce) begin
			take_q <= 1'b0;
			rvalid_q <= 1'b0;
			if (!tmr_done) begin
				tmr_q <= tmr_q - 8'h01;
			end
			unique case (state_q)
				asrp_pkg::HST_IDLE: begin
					if (req) begin
						// Every transfer carries its own address byte
						out_q <= {req_read, req_burst, req_addr};
						read_q <= req_read;
						left_q <= req_len;
						data_q <= 1'b0;
						last_q <= 1'b0;
						bit_q <= 3'h0;
						cs_n_q <= 1'b0;
						tmr_q <= 8'(HALF_CYCLES - 1);
						state_q <= asrp_pkg::HST_LEAD;
					end
				end
				asrp_pkg::HST_LEAD, asrp_pkg::HST_HIGH: begin
					if (tmr_done) begin
						tmr_q <= 8'(HALF_CYCLES - 1);
						if (last_q) begin
							cs_n_q <= 1'b1;
							tmr_q <= 8'(asrp_pkg::CS_IDLE_CYCLES - 1);
							state_q <= asrp_pkg::HST_GAP;
						end else begin
							// New bit goes out with the falling edge
							sclk_q <= 1'b0;
							mosi_q <= out_q[DATA_W-1];
							out_q <= {out_q[DATA_W-2:0], 1'b1};
							state_q <= asrp_pkg::HST_LOW;
						end
					end
				end
				asrp_pkg::HST_LOW: begin
					if (tmr_done) begin
						// Sample on the rising edge
						sclk_q <= 1'b1;
						in_q <= byte_in;
						bit_q <= bit_q + 3'h1;
						tmr_q <= 8'(HALF_CYCLES - 1);
						state_q <= asrp_pkg::HST_HIGH;
						if (bit_q == asrp_pkg::LAST_BIT) begin
							if (data_q && read_q) begin
								rdata_q <= byte_in;
								rvalid_q <= 1'b1;
							end
							if (left_q == '0) begin
								last_q <= 1'b1;
							end else begin
								left_q <= left_q - 1'b1;
								out_q <= wr_data;
								take_q <= 1'b1;
								data_q <= 1'b1;
							end
						end
					end
				end
				asrp_pkg::HST_GAP: begin
					if (tmr_done) begin
						state_q <= asrp_pkg::HST_IDLE;
					end
				end
				default: begin
					state_q <= asrp_pkg::HST_IDLE;
				end
			endcase
		end
	end

	// Data line held high while deselected; released for three-wire read data
	assign spi.host_o = cs_n_q ? 1'b1 : mosi_q;
	assign spi.host_oe = ~(three_wire & data_q & read_q & ~cs_n_q);
	assign spi.cs_n = cs_n_q;
	assign spi.sclk = sclk_q;
	assign wr_take = take_q;
	assign rd_data = rdata_q;
	assign rd_valid = rvalid_q;
	assign busy = (state_q != asrp_pkg::HST_IDLE);
endmodule

// ===== dv/asrp_spi_asserts.sv
// Link checks between the two port ends.
// Assumes link signals sampled on the system clock.
`timescale 1ns/10ps
module asrp_spi_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic host_o,
	input wire logic host_oe,
	input wire logic dev_o,
	input wire logic dev_sdo_oe,
	input wire logic dev_sdio_oe
);
	logic [6:0] gap_q;
	// Deselect run; preset in reset so the first frame is not judged
	always_ff @(posedge clk) begin
		if (rst) begin
			gap_q <= 7'h7f;
		end else if (!cs_n) begin
			gap_q <= 7'h00;
		end else if (gap_q != 7'h7f) begin
			gap_q <= gap_q + 7'h01;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_start;
		$fell(cs_n);
	endsequence
	sequence s_end;
		$rose(cs_n);
	endsequence
	sequence s_high;
		sclk && $past(sclk) && !cs_n && !$past(cs_n);
	endsequence
	chk_sclk_idle: assert property (cs_n |-> sclk)
		else $error("sclk low while deselected");
	chk_cs_gap: assert property (s_start |-> gap_q >= 7'h26)
		else $error("deselect gap short");
	chk_cs_lead: assert property (s_start |-> sclk [*2])
		else $error("sclk fell too soon");
	chk_cs_quiet: assert property (s_end |-> $past(sclk) && $past(sclk, 2))
		else $error("cs_n rose too soon");
	chk_host_hold: assert property (s_high |-> $stable(host_o))
		else $error("host data moved while sclk high");
	chk_dev_hold: assert property ($rose(sclk) && !cs_n |-> $stable(dev_o) ##1 $stable(dev_o))
		else $error("device data moved at rise");
	chk_sdio_clash: assert property (dev_sdio_oe && !cs_n |-> !host_oe)
		else $error("shared line clash");
	chk_oe_release: assert property (cs_n [*5] |-> !dev_sdo_oe && !dev_sdio_oe)
		else $error("device drives while deselected");
	chk_wire_mode: assert property (!(dev_sdo_oe && dev_sdio_oe))
		else $error("both device lines driven");
endmodule

// ===== dv/accel_spi_register_port_tb_top.sv
// Bench joining host and device ends over the link interface.
// Assumes a 250 MHz clock and an 80 ns serial clock period.
`timescale 1ns/10ps
module accel_spi_register_port_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	logic req_read = 1'b0;
	logic req_burst = 1'b0;
	logic [5:0] req_addr = 6'h00;
	logic [6:0] req_len = 7'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_take, rd_valid, busy, reg_wr_pulse, three_wire, selected;
	logic [7:0] rd_data, reg_wr_data, format_reg;
	logic [5:0] reg_wr_addr;
	logic [7:0] mem [64];
	logic [7:0] wq [$];
	logic [7:0] rq [$];
	int n_mismatch = 0;
	int n_compared = 0;
	int cyc = 0;
	asrp_spi_if u_asrp_spi_if ();
	asrp_device u_asrp_device (.clk, .rst, .ce(1'b1), .spi(u_asrp_spi_if), .reg_wr_pulse,
		.reg_wr_addr, .reg_wr_data, .format_reg, .three_wire, .selected);
	asrp_host #(.HALF_CYCLES(10)) u_asrp_host (.clk, .rst, .ce(1'b1), .spi(u_asrp_spi_if),
		.three_wire, .req, .req_read, .req_burst, .req_addr, .req_len, .wr_data, .wr_take,
		.rd_data, .rd_valid, .busy);
	asrp_spi_asserts u_asrp_spi_asserts (.clk, .rst, .cs_n(u_asrp_spi_if.cs_n),
		.sclk(u_asrp_spi_if.sclk), .host_o(u_asrp_spi_if.host_o),
		.host_oe(u_asrp_spi_if.host_oe), .dev_o(u_asrp_spi_if.dev_o),
		.dev_sdo_oe(u_asrp_spi_if.dev_sdo_oe), .dev_sdio_oe(u_asrp_spi_if.dev_sdio_oe));
	// System clock
	always #2 clk = ~clk;
	// Hang guard, about four times the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			finish_test();
		end
	end
	task finish_test;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] want);
		n_compared++;
		if (got !== want) begin
			n_mismatch++;
			$display("Error %0t: got %h want %h", $time, got, want);
		end
	endtask
	function automatic logic [7:0] exp_rd(input logic [5:0] a, input int i);
		return mem[6'(a + i)];
	endfunction
	task automatic fill(input int n);
		wq.delete();
		repeat (n) wq.push_back(8'($urandom));
	endtask
	// One framed transfer; data from wq, read bytes into rq
	task automatic xfer(input logic rd, input logic bu, input logic [5:0] a, input int n);
		int k;
		int w;
		k = 0;
		w = 0;
		rq.delete();
		req_read = rd;
		req_burst = bu;
		req_addr = a;
		// The host counts data bytes in req_len itself
		req_len = 7'(n);
		wr_data = wq[0];
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		while (busy === 1'b1) begin
			if (wr_take === 1'b1 && k + 1 < n) begin
				k++;
				wr_data = wq[k];
			end
			if (rd_valid === 1'b1) begin
				rq.push_back(rd_data);
				cmp8({7'h00, selected}, 8'h01);
			end
			if (reg_wr_pulse === 1'b1) begin
				cmp8({2'h0, reg_wr_addr}, {2'h0, 6'(a + w)});
				cmp8(reg_wr_data, wq[w]);
				w++;
			end
			@(negedge clk);
		end
		cmp8({7'h00, selected}, 8'h00);
	endtask
	// Write and mirror; without the burst flag only the first byte lands
	task automatic wr(input logic bu, input logic [5:0] a, input int n);
		xfer(1'b0, bu, a, n);
		for (int i = 0; i < (bu ? n : 1); i++) mem[6'(a + i)] = wq[i];
	endtask
	task automatic rd_chk(input logic [5:0] a, input int n);
		fill(n);
		xfer(1'b1, n > 1, a, n);
		cmp8(8'(rq.size()), 8'(n));
		foreach (rq[i]) cmp8(rq[i], exp_rd(a, i));
	endtask
	// Main sequence
	initial begin
		logic [5:0] a;
		int n;
		void'($urandom(11));
		foreach (mem[i]) mem[i] = 8'h00;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		cmp8(format_reg, 8'h00);
		rd_chk(6'h31, 1);
		// Random traffic kept below the format register
		repeat (6) begin
			a = 6'($urandom % 44);
			n = 1 + $urandom % 4;
			fill(n);
			wr(1'($urandom), a, n);
			rd_chk(a, n);
		end
		fill(3);
		wr(1'b0, 6'h10, 3);
		rd_chk(6'h10, 3);
		fill(3);
		wr(1'b1, 6'h3e, 3);
		rd_chk(6'h3e, 3);
		wq = '{8'hc3};
		wr(1'b0, 6'h31, 1);
		cmp8({7'h00, three_wire}, 8'h01);
		fill(4);
		wr(1'b1, 6'h05, 4);
		rd_chk(6'h05, 4);
		rd_chk(6'h31, 1);
		wq = '{8'hbf};
		wr(1'b0, 6'h31, 1);
		cmp8({7'h00, three_wire}, 8'h00);
		rd_chk(6'h3e, 3);
		finish_test();
	end
endmodule
